/* verilog/uart_efc_pkg.sv */
// Purpose: Shared constants and types for the enhanced UART configuration block.
// Assumes: One host bus with a 3-bit address and 8-bit data.
// Notes: Offsets are the 3-bit bus addresses of one channel.
package uart_efc_pkg;
  // Bus offsets.
  localparam logic [2:0] OFS_DIV_LOW = 3'h0;
  localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_EFR = 3'h2;
  localparam logic [2:0] OFS_FCR = 3'h2;
  localparam logic [2:0] OFS_LCR = 3'h3;
  localparam logic [2:0] OFS_MCR = 3'h4;
  localparam logic [2:0] OFS_THRESH = 3'h6;
  localparam logic [2:0] OFS_TRIGGER = 3'h7;
  localparam logic [2:0] OFS_SPECIAL = 3'h7;
  localparam logic [2:0] OFS_FIFO_READY = 3'h7;
  // Special line control values that open banks.
  localparam logic [7:0] LCR_ENH_KEY = 8'hBF;
  localparam int LCR_DLAB_BIT = 7;
  // Field positions.
  localparam int EFR_CTS_BIT = 7;
  localparam int EFR_RTS_BIT = 6;
  localparam int EFR_SPECIAL_BIT = 5;
  localparam int EFR_ENH_BIT = 4;
  localparam int IER_SLEEP_BIT = 4;
  localparam int MCR_BANK_BIT = 6;
  localparam int MCR_LOOP_BIT = 4;
  localparam int MCR_RDY_BIT = 2;
  localparam int MCR_RTS_BIT = 1;
  localparam int IIR_SPECIAL_BIT = 4;
  // Protected field masks.
  localparam logic [7:0] IER_ENH_MASK = 8'hF0;
  localparam logic [7:0] FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] MCR_ENH_MASK = 8'hE0;
  // Reset values.
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  // Trigger levels picked by a two-bit select field of fifo_control_reg.
  localparam logic [6:0] SEL_LEVEL0 = 7'h08;
  localparam logic [6:0] SEL_LEVEL1 = 7'h10;
  localparam logic [6:0] SEL_LEVEL2 = 7'h20;
  localparam logic [6:0] SEL_LEVEL3 = 7'h38;
  // Register selected by a bus access.
  typedef enum logic [3:0] {
    SEL_NONE = 4'b0000,
    SEL_DLOW = 4'b0001,
    SEL_DHIGH = 4'b0010,
    SEL_EFRR = 4'b0011,
    SEL_SPEC = 4'b0100,
    SEL_THR = 4'b0101,
    SEL_TRG = 4'b0110,
    SEL_RDY = 4'b0111,
    SEL_IER = 4'b1000,
    SEL_FCR = 4'b1001,
    SEL_LCR = 4'b1010,
    SEL_MCR = 4'b1011
  } reg_sel_t;
endpackage : uart_efc_pkg

/* verilog/uart_enhanced_flow_config.sv */
// Purpose: Enhanced feature, divisor, flow threshold and trigger registers of one channel.
// Assumes: Bus strobes are synchronous to clk; clear-to-send arrives from a pin.
// Notes: Read data appears one cycle after the read strobe.
`timescale 1ns/1ps
module uart_enhanced_flow_config
  import uart_efc_pkg::*;
#(
  parameter int FILL_W = 7
)
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Host bus.
  input wire logic cs_n,
  input wire logic other_cs_n,
  input wire logic [2:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // Receiver and FIFO status.
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic [FILL_W-1:0] rx_fill,
  input wire logic [1:0] tx_ready,
  input wire logic [1:0] rx_ready,
  // Modem pins.
  input wire logic cts_n,
  output logic rts_n,
  // Configuration to the datapath.
  output logic tx_allowed,
  output logic [15:0] divisor,
  output logic [3:0] sw_flow_mode,
  output logic special_flag,
  output logic [FILL_W-1:0] tx_trigger,
  output logic [FILL_W-1:0] rx_trigger
);

  logic [7:0] line_control_reg;
  logic [7:0] interrupt_enable_reg;
  logic [7:0] fifo_control_reg;
  logic [7:0] modem_control_reg;
  logic [7:0] enhanced_feature_ctrl;
  logic [7:0] thresh;
  logic [7:0] trig;
  logic [7:0] spec_char;
  logic [2:0] cts_sync;
  logic cts_high;
  logic selected;
  logic wr_hit;
  logic rd_hit;
  logic enh;
  reg_sel_t sel;
  logic [7:0] next_rdata;
  logic [FILL_W-1:0] halt_level;
  logic [FILL_W-1:0] resume_level;
  logic cts_agree;
  logic spec_hit;
  logic ident_rd;

  // Decodes an address in the current bank state to a register.
  function automatic reg_sel_t decode(input logic [2:0] a, input logic [7:0] lc,
                                      input logic [7:0] mc, input logic is_rd);
    reg_sel_t s;
    s = SEL_NONE;
    if (lc == LCR_ENH_KEY)
    begin
      if (a == OFS_EFR) s = SEL_EFRR;
      else if (a == OFS_SPECIAL) s = SEL_SPEC;
      else if (a == OFS_LCR) s = SEL_LCR;
    end
    else if (lc[LCR_DLAB_BIT] && (a == OFS_DIV_LOW))
      s = SEL_DLOW;
    else if (lc[LCR_DLAB_BIT] && (a == OFS_DIV_HIGH))
      s = SEL_DHIGH;
    else if (mc[MCR_BANK_BIT] && (a == OFS_THRESH))
      s = SEL_THR;
    else if (mc[MCR_BANK_BIT] && (a == OFS_TRIGGER))
      s = SEL_TRG;
    else if (is_rd && mc[MCR_RDY_BIT] && !mc[MCR_LOOP_BIT] && (a == OFS_FIFO_READY))
      s = SEL_RDY;
    else if (a == OFS_IER) s = SEL_IER;
    else if (a == OFS_FCR) s = SEL_FCR;
    else if (a == OFS_LCR) s = SEL_LCR;
    else if (a == OFS_MCR) s = SEL_MCR;
    return s;
  endfunction : decode

  // Maps a two-bit select field of fifo_control_reg to a level.
  function automatic logic [FILL_W-1:0] sel_level(input logic [1:0] f);
    logic [6:0] v;
    case (f)
      2'b00: v = SEL_LEVEL0;
      2'b01: v = SEL_LEVEL1;
      2'b10: v = SEL_LEVEL2;
      default: v = SEL_LEVEL3;
    endcase
    return FILL_W'(v);
  endfunction : sel_level

  // Nibble scaled to bytes (times four).
  function automatic logic [FILL_W-1:0] nib_bytes(input logic [3:0] n);
    return FILL_W'({n, 2'b00});
  endfunction : nib_bytes

  // Picks the programmed level, or the select-field level when the nibble is zero.
  function automatic logic [FILL_W-1:0] eff_level(input logic [3:0] n, input logic [1:0] f);
    logic [FILL_W-1:0] v;
    if (n != 4'h0)
      v = nib_bytes(n);
    else
      v = sel_level(f);
    return v;
  endfunction : eff_level

  // Merges a write, keeping the masked bits unless enhanced writes are open.
  function automatic logic [7:0] guarded(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] mask, input logic en);
    logic [7:0] v;
    v = en ? new_v : ((old_v & mask) | (new_v & ~mask));
    return v;
  endfunction : guarded

  // Strobe qualification; the ready register answers either channel's select.
  assign selected = !cs_n;
  assign wr_hit = ce && wr && selected;
  assign rd_hit = ce && rd && (selected || !other_cs_n);
  assign enh = enhanced_feature_ctrl[EFR_ENH_BIT];
  assign sel = decode(addr, line_control_reg, modem_control_reg, rd);
  assign halt_level = nib_bytes(thresh[3:0]);
  assign resume_level = nib_bytes(thresh[7:4]);

  // Qualified events: pin stages agreeing, a character match and the clearing read.
  assign cts_agree = (cts_sync[1] == cts_sync[2]);
  assign spec_hit = enhanced_feature_ctrl[EFR_SPECIAL_BIT] && rx_char_valid && (rx_char == spec_char);
  assign ident_rd = rd_hit && selected && (sel == SEL_FCR);

  // Clear-to-send pin synchroniser; a level counts once stages two and three agree.
  always_ff @(posedge clk)
  begin
    if (rst)
      cts_sync <= 3'h0;
    else if (ce)
      cts_sync <= {cts_sync[1:0], cts_n};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cts_high <= 1'b0;
    else if (ce && cts_agree)
      cts_high <= cts_sync[2];
  end

  // Base registers; protected fields keep their value while enhanced mode is off.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      line_control_reg <= REG_RESET;
      interrupt_enable_reg <= REG_RESET;
      fifo_control_reg <= REG_RESET;
      modem_control_reg <= REG_RESET;
    end
    else if (wr_hit)
    begin
      case (sel)
        SEL_LCR: line_control_reg <= wdata;
        SEL_IER: interrupt_enable_reg <= guarded(interrupt_enable_reg, wdata, IER_ENH_MASK, enh);
        SEL_FCR: fifo_control_reg <= guarded(fifo_control_reg, wdata, FCR_ENH_MASK, enh);
        SEL_MCR: modem_control_reg <= guarded(modem_control_reg, wdata, MCR_ENH_MASK, enh);
        default: line_control_reg <= line_control_reg;
      endcase
    end
  end

  // Enhanced control register, reachable only behind the BFh key.
  always_ff @(posedge clk)
  begin
    if (rst)
      enhanced_feature_ctrl <= REG_RESET;
    else if (wr_hit && (sel == SEL_EFRR))
      enhanced_feature_ctrl <= wdata;
  end

  // Special character value, behind the same key.
  always_ff @(posedge clk)
  begin
    if (rst)
      spec_char <= REG_RESET;
    else if (wr_hit && (sel == SEL_SPEC))
      spec_char <= wdata;
  end

  // Divisor latches, frozen while sleep is enabled.
  always_ff @(posedge clk)
  begin
    if (rst)
      divisor <= DIV_RESET;
    else if (wr_hit && !interrupt_enable_reg[IER_SLEEP_BIT])
    begin
      if (sel == SEL_DLOW)
        divisor[7:0] <= wdata;
      else if (sel == SEL_DHIGH)
        divisor[15:8] <= wdata;
    end
  end

  // Threshold register needs enhanced mode and the bank bit.
  always_ff @(posedge clk)
  begin
    if (rst)
      thresh <= REG_RESET;
    else if (wr_hit && enh && modem_control_reg[MCR_BANK_BIT] && (sel == SEL_THR))
      thresh <= wdata;
  end

  // Trigger register carries the same write guard.
  always_ff @(posedge clk)
  begin
    if (rst)
      trig <= REG_RESET;
    else if (wr_hit && enh && modem_control_reg[MCR_BANK_BIT] && (sel == SEL_TRG))
      trig <= wdata;
  end

  // Effective transmit trigger: a non-zero nibble overrides the select field.
  always_ff @(posedge clk)
  begin
    if (rst)
      tx_trigger <= '0;
    else if (ce)
      tx_trigger <= eff_level(trig[3:0], fifo_control_reg[5:4]);
  end

  // Effective receive trigger, chosen the same way for its own direction.
  always_ff @(posedge clk)
  begin
    if (rst)
      rx_trigger <= '0;
    else if (ce)
      rx_trigger <= eff_level(trig[7:4], fifo_control_reg[7:6]);
  end

  // Special character flag: a new match wins over the clearing read.
  always_ff @(posedge clk)
  begin
    if (rst)
      special_flag <= 1'b0;
    else if (ce && spec_hit)
      special_flag <= 1'b1;
    else if (ident_rd)
      special_flag <= 1'b0;
  end

  // Ready-to-send pin: hysteresis between halt and resume levels when automatic.
  always_ff @(posedge clk)
  begin
    if (rst)
      rts_n <= 1'b1;
    else if (ce)
    begin
      if (!enhanced_feature_ctrl[EFR_RTS_BIT])
        rts_n <= !modem_control_reg[MCR_RTS_BIT];
      else if (rx_fill >= halt_level)
        rts_n <= 1'b1;
      else if (rx_fill <= resume_level)
        rts_n <= 1'b0;
    end
  end

  // Transmit gate: a synchronised stop level halts sending while flow control is on.
  always_ff @(posedge clk)
  begin
    if (rst)
      tx_allowed <= 1'b1;
    else if (ce)
      tx_allowed <= !(enhanced_feature_ctrl[EFR_CTS_BIT] && cts_high);
  end

  // Software flow selection follows the low control bits one cycle later.
  always_ff @(posedge clk)
  begin
    if (rst)
      sw_flow_mode <= 4'h0;
    else if (ce)
      sw_flow_mode <= enhanced_feature_ctrl[3:0];
  end

  // Read multiplexer.
  always_comb
  begin
    next_rdata = 8'h00;
    case (sel)
      SEL_DLOW: next_rdata = divisor[7:0];
      SEL_DHIGH: next_rdata = divisor[15:8];
      SEL_EFRR: next_rdata = enhanced_feature_ctrl;
      SEL_SPEC: next_rdata = spec_char;
      SEL_THR: next_rdata = thresh;
      SEL_TRG: next_rdata = trig;
      SEL_RDY: next_rdata = {2'b00, rx_ready, 2'b00, tx_ready};
      SEL_IER: next_rdata = interrupt_enable_reg;
      SEL_FCR: next_rdata = {3'b000, special_flag, 4'h1};
      SEL_LCR: next_rdata = line_control_reg;
      SEL_MCR: next_rdata = modem_control_reg;
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data register; only the ready register answers the other channel's select.
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd_hit)
      rdata <= (selected || (sel == SEL_RDY)) ? next_rdata : 8'h00;
  end

endmodule : uart_enhanced_flow_config

/* tb/uart_efc_assertions.sv */
// Purpose: Port-level checks for the enhanced UART configuration block.
// Assumes: One clock; rst is synchronous and active high.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
module uart_efc_assertions #(
  parameter int FILL_W = 7
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Host bus.
  input wire logic ce,
  input wire logic cs_n,
  input wire logic other_cs_n,
  input wire logic [2:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Line side and status.
  input wire logic rx_char_valid,
  input wire logic [FILL_W-1:0] rx_fill,
  input wire logic [1:0] tx_ready,
  input wire logic [1:0] rx_ready,
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic tx_allowed,
  input wire logic [15:0] divisor,
  input wire logic [3:0] sw_flow_mode,
  input wire logic special_flag,
  input wire logic [FILL_W-1:0] tx_trigger,
  input wire logic [FILL_W-1:0] rx_trigger
);
  // Every check runs on the one clock and sleeps through reset.
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A ready register read made through the other channel's select.
  sequence ready_rd;
    ce && rd && cs_n && !other_cs_n && addr == 3'h7;
  endsequence
  // The transmitter being stopped.
  sequence tx_stop;
    $fell(tx_allowed);
  endsequence
  // Checks of outputs against their causes.
  reset_vals_a: assert property ($past(rst) |-> tx_allowed && rts_n && !special_flag
    && divisor == 16'h0000 && sw_flow_mode == 4'h0) else $error("Bad reset values.");
  cts_stop_a: assert property (tx_stop |-> $past(cts_n, 2) || $past(cts_n, 3)
    || $past(cts_n, 4)) else $error("Transmit stopped without a stop request.");
  special_src_a: assert property ($rose(special_flag) |-> $past(rx_char_valid))
    else $error("Special flag set without a character.");
  trig_step_a: assert property (tx_trigger[1:0] == 2'b00 && rx_trigger[1:0] == 2'b00
    && tx_trigger <= 60 && rx_trigger <= 60) else $error("Trigger level off step.");
  cfg_hold_a: assert property (!$past(wr) && !$past(wr, 2) && !$past(rst) |-> $stable(divisor)
    && $stable(sw_flow_mode)) else $error("Configuration changed without a write.");
  read_hold_a: assert property (!$past(rd) && !$past(rst) |-> $stable(rdata))
    else $error("Read data changed without a read.");
  ready_data_a: assert property (ready_rd |=> rdata == 8'h00
    || rdata == {2'b00, $past(rx_ready), 2'b00, $past(tx_ready)}) else $error("Bad ready data.");
  rts_cause_a: assert property ($changed(rts_n) && !$past(rst) |-> $past(wr) || $past(wr, 2)
    || $past(rx_fill) != $past(rx_fill, 2)) else $error("Ready-to-send moved without cause.");
endmodule : uart_efc_assertions

bind uart_enhanced_flow_config uart_efc_assertions #(.FILL_W(FILL_W)) checker_inst (.*);

/* tb/uart_efc_remote.sv */
// Purpose: Remote serial device on the line side of the channel.
// Assumes: The bench calls its tasks.
// Notes: Character data is scrambled once its strobe drops.
`timescale 1ns/1ps
module uart_efc_remote
(
  // Clock.
  input wire logic clk,
  // Line side.
  output logic cts_n,
  output logic rx_char_valid,
  output logic [7:0] rx_char
);
  // Ready to receive, no character at start.
  initial
  begin
    cts_n = 1'b0;
    rx_char_valid = 1'b0;
    rx_char = 8'h5A;
  end
  // Raise or drop the stop request.
  task automatic hold(input logic stop);
    @(posedge clk);
    cts_n <= stop;
  endtask : hold
  // One character strobe; stale data must not be trusted.
  task automatic send(input logic [7:0] ch);
    @(posedge clk);
    rx_char_valid <= 1'b1;
    rx_char <= ch;
    @(posedge clk);
    rx_char_valid <= 1'b0;
    rx_char <= ~ch;
  endtask : send
endmodule : uart_efc_remote

/* tb/testbench.sv */
// Purpose: Self-checking bench for the enhanced UART configuration block.
// Assumes: 200 MHz clock; inputs change on the rising edge.
// Notes: Ready inputs and ce stay constant.
`timescale 1ns/1ps
module testbench
  import uart_efc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, cs_n = 1'b1, other_cs_n = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, rx_char, got;
  logic [6:0] rx_fill = 7'h00, tx_trigger, rx_trigger;
  logic [1:0] tx_ready = 2'b10, rx_ready = 2'b01;
  logic rx_char_valid, cts_n, rts_n, tx_allowed, special_flag;
  logic [15:0] divisor;
  logic [3:0] sw_flow_mode;
  int num_errors = 0, num_checks = 0;
  // Block under test and the far-side device.
  uart_enhanced_flow_config #(.FILL_W(7)) uart_enhanced_flow_config_inst (.*);
  uart_efc_remote uart_efc_remote_inst (.clk, .cts_n, .rx_char_valid, .rx_char);
  // Clock of 5 ns period.
  initial forever #2.5 clk = ~clk;
  // Compare and count.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Let n edges pass, then sample at the falling edge.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle
  // Write cycle, taken on its second edge.
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    {cs_n, addr, wdata, wr} <= {1'b0, a, d, 1'b1};
    @(posedge clk);
    {cs_n, wr} <= 2'b10;
  endtask : wr_reg
  // Read cycle through either select; data lands after the taking edge.
  task automatic rd_reg(input logic [2:0] a, input logic other);
    @(posedge clk);
    {cs_n, other_cs_n, addr, rd} <= {other, !other, a, 1'b1};
    @(posedge clk);
    {cs_n, other_cs_n, rd} <= 3'b110;
    @(negedge clk);
    got = rdata;
  endtask : rd_reg
  task automatic t_reset;
    settle(1);
    chk(divisor, 16'h0000);
    chk(16'({tx_allowed, rts_n, special_flag, sw_flow_mode}), 16'h0060);
    chk(16'(tx_trigger), 16'(SEL_LEVEL0));
    chk(16'(rx_trigger), 16'(SEL_LEVEL0));
    $display("reset test done");
  endtask : t_reset
  task automatic t_bank;
    wr_reg(OFS_LCR, LCR_ENH_KEY);
    wr_reg(OFS_EFR, 8'h0A);
    rd_reg(OFS_EFR, 1'b0);
    chk(16'(got), 16'h000A);
    chk(16'(sw_flow_mode), 16'h000A);
    wr_reg(OFS_LCR, 8'h00);
    wr_reg(OFS_IER, 8'hF3);
    wr_reg(OFS_FCR, 8'hB0);
    wr_reg(OFS_MCR, 8'h40);
    wr_reg(OFS_TRIGGER, 8'h35);
    rd_reg(OFS_IER, 1'b0);
    chk(16'(got), 16'h0003);
    rd_reg(OFS_MCR, 1'b0);
    chk(16'(got), 16'h0000);
    chk(16'(tx_trigger), 16'(SEL_LEVEL0));
    chk(16'(rx_trigger), 16'(SEL_LEVEL2));
    $display("bank test done");
  endtask : t_bank
  task automatic t_flow;
    logic [6:0] fills[4] = '{7'd39, 7'd40, 7'd9, 7'd8};
    logic exp_rts[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    wr_reg(OFS_LCR, LCR_ENH_KEY);
    wr_reg(OFS_EFR, 8'h1A);
    wr_reg(OFS_LCR, 8'h00);
    wr_reg(OFS_FCR, 8'h10);
    wr_reg(OFS_MCR, 8'h40);
    wr_reg(OFS_THRESH, 8'h2A);
    settle(1);
    chk(16'({tx_trigger, rx_trigger}), 16'({SEL_LEVEL1, SEL_LEVEL0}));
    wr_reg(OFS_TRIGGER, 8'h35);
    settle(1);
    chk(16'({tx_trigger, rx_trigger}), 16'({7'd20, 7'd12}));
    rd_reg(OFS_THRESH, 1'b0);
    chk(16'(got), 16'h002A);
    wr_reg(OFS_LCR, LCR_ENH_KEY);
    wr_reg(OFS_EFR, 8'h5A);
    wr_reg(OFS_LCR, 8'h00);
    foreach (fills[i])
    begin
      @(posedge clk) rx_fill <= fills[i];
      settle(1);
      chk(16'(rts_n), 16'(exp_rts[i]));
    end
    $display("flow test done");
  endtask : t_flow
  task automatic t_divisor;
    wr_reg(OFS_LCR, 8'h80);
    wr_reg(OFS_DIV_LOW, 8'h34);
    wr_reg(OFS_DIV_HIGH, 8'h12);
    settle(1);
    chk(divisor, 16'h1234);
    wr_reg(OFS_LCR, 8'h00);
    wr_reg(OFS_IER, 8'h10);
    wr_reg(OFS_LCR, 8'h80);
    wr_reg(OFS_DIV_LOW, 8'hFF);
    settle(1);
    chk(divisor, 16'h1234);
    $display("divisor test done");
  endtask : t_divisor
  task automatic t_line;
    wr_reg(OFS_LCR, LCR_ENH_KEY);
    wr_reg(OFS_EFR, 8'hFA);
    wr_reg(OFS_SPECIAL, 8'h13);
    wr_reg(OFS_LCR, 8'h00);
    uart_efc_remote_inst.hold(1'b1);
    settle(6);
    chk(16'(tx_allowed), 16'h0000);
    uart_efc_remote_inst.hold(1'b0);
    settle(6);
    chk(16'(tx_allowed), 16'h0001);
    uart_efc_remote_inst.send(8'h14);
    settle(1);
    chk(16'(special_flag), 16'h0000);
    uart_efc_remote_inst.send(8'h13);
    settle(1);
    chk(16'(special_flag), 16'h0001);
    rd_reg(OFS_FCR, 1'b0);
    chk(16'(got), 16'h0011);
    chk(16'(special_flag), 16'h0000);
    $display("line test done");
  endtask : t_line
  task automatic t_ready;
    wr_reg(OFS_MCR, 8'h04);
    rd_reg(OFS_FIFO_READY, 1'b1);
    chk(16'(got), 16'h0012);
    rd_reg(OFS_FIFO_READY, 1'b0);
    chk(16'(got), 16'h0012);
    wr_reg(OFS_MCR, 8'h14);
    rd_reg(OFS_FIFO_READY, 1'b1);
    chk(16'(got), 16'h0000);
    $display("ready test done");
  endtask : t_ready
  // Print the counts and the verdict, then stop.
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // Main sequence after six reset cycles.
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_bank();
    t_flow();
    t_divisor();
    t_line();
    t_ready();
    report_and_stop();
  end
  // Watchdog, far beyond the expected run length.
  initial
  begin
    #20000;
    num_errors++;
    report_and_stop();
  end
endmodule : testbench
